// ==== hdl/reset_watchdog_clock_monitor_map.vh ====
`ifndef RESET_WATCHDOG_CLOCK_MONITOR_MAP_VH
`define RESET_WATCHDOG_CLOCK_MONITOR_MAP_VH

// Register indices; the byte address is four times the index.
`define IDX_SYSTEM_OPTIONS   14'h1039
`define IDX_SERVICE          14'h103A
`define IDX_STATUS           14'h103B
`define IDX_TEST_CONTROL     14'h103E
`define IDX_SYSTEM_CONFIG    14'h103F

// system_options fields and reset value.
`define OPT_RESET            8'h10
`define OPT_CONVERTER_PU     7
`define OPT_CONVERTER_CLK    6
`define OPT_IRQ_EDGE         5
`define OPT_STARTUP_DLY      4
`define OPT_CLOCK_WATCH      3
`define OPT_RATE_HI          1
`define OPT_RATE_LO          0
`define OPT_ONCE_MASK        8'h33
`define OPT_ANY_MASK         8'hC8

// system_configuration fields and reset value.
`define CFG_RESET            8'h00
`define CFG_WATCHDOG_DISABLE 2

// test_control_reg fields.
`define TEST_SUPPRESS_BIT    0

// Watchdog service patterns.
`define SERVICE_ARM          8'h55
`define SERVICE_CLEAR        8'hAA

// Reset sequence timing in bus clock cycles.
`define POR_CYCLES           13'd4064
`define PIN_DRIVE_CYCLES     3'd4
`define PIN_SETTLE_CYCLES    3'd2
`define ONCE_WINDOW_CYCLES   7'd64

// Reset vectors.
`define VEC_NORM_PIN         16'hFFFE
`define VEC_NORM_CLOCK       16'hFFFC
`define VEC_NORM_WATCHDOG    16'hFFFA
`define VEC_SPEC_PIN         16'hBFFE
`define VEC_SPEC_CLOCK       16'hBFFC
`define VEC_SPEC_WATCHDOG    16'hBFFA

// AXI responses.
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== hdl/reset_watchdog_clock_monitor.v ====
// Operation
// (RULE1) Reset is external if the pin has not risen two cycles after release.
// (RULE2) Any recognised reset drives the reset pin low four cycles, then releases. Power-on reset here never drives the pin.
// (RULE3) Pin sampled two cycles after release; low means external reset.
// (RULE4) Pin high at sample means watchdog or clock-loss caused the reset.
// (RULE5) Outside reset circuits must not use slow RC delays on the pin.
// (RULE6) Watchdog disable bit: 0 enables watchdog resets, 1 disables them.
// (RULE7) Watchdog enable changes act only after the next system reset.
// (RULE8) Special modes suppress watchdog resets until the suppress bit is cleared.
// (RULE9) Watchdog period is 2^15 bus cycles times 1, 4, 16 or 64.
// (RULE10) Reset clears the rate select, giving the shortest timeout.
// (RULE11) Once-bits take one write within 64 cycles in normal modes.
// (RULE12) Software writes 55 hex then AA hex to service the watchdog.
// (RULE13) Other accesses may intervene; only ordered arm then clear resets timer.
// (RULE14) An enabled watchdog that times out starts a system reset.
// (RULE15) Clock loss beyond the RC delay starts reset when monitor enabled.
// (RULE16) Clock-loss timing runs independently of the system clock.
// (RULE17) Clock watch enable is always writable, reset to 0, 1 enables.
// (RULE18) Below 10 kHz flags failure; 200 kHz or more never flags.
// (RULE19) Stop mode with clock watch enabled produces a reset.
// (RULE20) Interrupt edge bit: 0 level-sensitive, 1 edge-sensitive only.
// (RULE21) Normal modes vector FFFE pin, FFFC clock failure, FFFA watchdog.
// (RULE22) Special modes vector BFFE pin, BFFC clock failure, BFFA watchdog.
// (RULE23) Power-on holds reset 4064 cycles and while the pin stays low.
// (RULE24) Any other service value leaves the watchdog timer alone.
// (RULE25) Simultaneous causes: pin first, then clock failure, then watchdog.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "reset_watchdog_clock_monitor_map.vh"

module reset_watchdog_clock_monitor #(
    parameter WD_BASE_LOG2 = 15,
    parameter ADDR_W       = 16
) (
    // Clock and power-on reset.
    input  wire              core_clk,
    input  wire              resetn,
    // AXI4-Lite slave.
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Open-drain reset pin.
    input  wire              resetPinIn,
    output reg               resetPinOut,
    output reg               resetPinOe,
    // Mode and clock-loss inputs.
    input  wire              specialModeIn,
    input  wire              stopModeIn,
    input  wire              rcClockLostIn,
    // Outputs to the rest of the chip.
    output reg               coreResetn_r,
    output reg  [15:0]       resetVector_r,
    output reg               irqEdgeSelect_r,
    output reg               oscStartupDelayEn_r,
    output reg               converterPowerUp_r,
    output reg               converterClockSel_r
);

    localparam S_POR    = 3'd0;
    localparam S_RUN    = 3'd1;
    localparam S_DRIVE  = 3'd2;
    localparam S_SETTLE = 3'd3;
    localparam S_HOLD   = 3'd4;

    localparam WD_W = WD_BASE_LOG2 + 6;
    localparam [7:0] CFG_INIT = `CFG_RESET;

    // Timeout length for a rate code: base times 1, 4, 16 or 64.
    function [WD_W-1:0] wdLimit;
        input [1:0] rate;
        begin
            wdLimit = {{(WD_W-1){1'b0}}, 1'b1} << (WD_BASE_LOG2 + 2 * rate);
        end
    endfunction

    // Vector for a cause in the current mode.
    function [15:0] vectorFor;
        input spec;
        input isPin;
        input isClock;
        begin
            if (isPin)
                vectorFor = spec ? `VEC_SPEC_PIN : `VEC_NORM_PIN;
            else if (isClock)
                vectorFor = spec ? `VEC_SPEC_CLOCK : `VEC_NORM_CLOCK;
            else
                vectorFor = spec ? `VEC_SPEC_WATCHDOG : `VEC_NORM_WATCHDOG;
        end
    endfunction

    reg  [2:0]       state_r;
    reg  [12:0]      seqCnt_r;
    reg              causeClock_r;
    reg              causeWd_r;
    reg              lastPin_r;
    reg              lastClock_r;
    reg              lastWd_r;
    reg              special_r;
    reg  [7:0]       options_r;
    reg  [7:0]       config_r;
    reg              wdDisableActive_r;
    reg              suppress_r;
    reg              armed_r;
    reg  [WD_W-1:0]  wdCount_r;
    reg  [6:0]       onceCnt_r;
    reg              onceUsed_r;
    reg              awHeld_r;
    reg              wHeld_r;
    reg  [13:0]      awIdx_r;
    reg  [7:0]       wByte_r;
    reg              wLane_r;

    wire             inReset   = (state_r != S_RUN);
    // Restarting at each expiry, fired or not, bounds the next timeout.
    wire             wdExpire  = (wdCount_r >= wdLimit(options_r[1:0]) -
                                  {{(WD_W-1){1'b0}}, 1'b1}); // RULE9
    wire             wdFire    = ~wdDisableActive_r & ~suppress_r
                               & wdExpire; // RULE14
    // The RC cell keeps timing without core_clk; only its verdict is used.
    wire             clockFail = options_r[`OPT_CLOCK_WATCH] // RULE16 RULE18
                               & (rcClockLostIn | stopModeIn); // RULE15 RULE19
    wire             doWrite   = awHeld_r & wHeld_r & ~s_axi_bvalid;
    wire [13:0]      arIdx     = s_axi_araddr[15:2];
    wire             onceOpen  = special_r |
                                 (~onceUsed_r &
                                  (onceCnt_r < `ONCE_WINDOW_CYCLES)); // RULE11
    wire             wrOpt     = doWrite & wLane_r &
                                 (awIdx_r == `IDX_SYSTEM_OPTIONS);
    wire             wrSvc     = doWrite & wLane_r & (awIdx_r == `IDX_SERVICE);
    wire             wdClear   = wrSvc & armed_r &
                                 (wByte_r == `SERVICE_CLEAR); // RULE13

    function isMapped;
        input [13:0] idx;
        begin
            isMapped = (idx == `IDX_SYSTEM_OPTIONS) | (idx == `IDX_SERVICE) |
                       (idx == `IDX_STATUS) | (idx == `IDX_TEST_CONTROL) |
                       (idx == `IDX_SYSTEM_CONFIG);
        end
    endfunction

    // Reset sequencer and pin driver.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r       <= S_POR;
            seqCnt_r      <= 13'h0000;
            causeClock_r  <= 1'b0;
            causeWd_r     <= 1'b0;
            lastPin_r     <= 1'b1;
            lastClock_r   <= 1'b0;
            lastWd_r      <= 1'b0;
            resetPinOut   <= 1'b0;
            resetPinOe    <= 1'b0;
            coreResetn_r  <= 1'b0;
            resetVector_r <= `VEC_NORM_PIN;
        end else begin
            resetPinOut <= 1'b0;
            case (state_r)
                S_POR: begin
                    if (seqCnt_r < `POR_CYCLES - 13'd1) begin
                        seqCnt_r <= seqCnt_r + 13'd1; // RULE23
                    end else if (resetPinIn) begin // RULE23
                        state_r       <= S_RUN;
                        coreResetn_r  <= 1'b1;
                        resetVector_r <= vectorFor(special_r, 1'b1, 1'b0);
                    end
                end
                S_RUN: begin
                    if (!resetPinIn || clockFail || wdFire) begin
                        state_r      <= S_DRIVE; // RULE2
                        seqCnt_r     <= 13'h0000;
                        causeClock_r <= clockFail;
                        causeWd_r    <= wdFire;
                        resetPinOe   <= 1'b1; // RULE2
                        coreResetn_r <= 1'b0;
                    end
                end
                S_DRIVE: begin
                    if (seqCnt_r[2:0] == `PIN_DRIVE_CYCLES - 3'd1) begin
                        state_r    <= S_SETTLE;
                        seqCnt_r   <= 13'h0000;
                        resetPinOe <= 1'b0; // RULE2
                    end else begin
                        seqCnt_r   <= seqCnt_r + 13'd1;
                    end
                end
                S_SETTLE: begin
                    if (seqCnt_r[2:0] == `PIN_SETTLE_CYCLES - 3'd1) begin
                        // A pin still low was held by someone outside.
                        if (!resetPinIn) begin // RULE1 RULE3
                            state_r     <= S_HOLD;
                            lastPin_r   <= 1'b1;
                            lastClock_r <= 1'b0;
                            lastWd_r    <= 1'b0;
                        end else begin // RULE4
                            state_r       <= S_RUN;
                            coreResetn_r  <= 1'b1;
                            lastPin_r     <= ~causeClock_r & ~causeWd_r;
                            lastClock_r   <= causeClock_r;
                            lastWd_r      <= ~causeClock_r & causeWd_r;
                            resetVector_r <= vectorFor(special_r,
                                ~causeClock_r & ~causeWd_r,
                                causeClock_r); // RULE25 RULE21 RULE22
                        end
                    end else begin
                        seqCnt_r <= seqCnt_r + 13'd1;
                    end
                end
                S_HOLD: begin
                    if (resetPinIn) begin
                        state_r       <= S_RUN;
                        coreResetn_r  <= 1'b1;
                        resetVector_r <= vectorFor(special_r, 1'b1,
                                                   1'b0); // RULE25
                    end
                end
                default: begin
                    state_r    <= S_POR;
                    seqCnt_r   <= 13'h0000;
                    resetPinOe <= 1'b0;
                end
            endcase
        end
    end

    // Mode strap, options, configuration, suppress bit.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            special_r         <= 1'b0;
            options_r         <= `OPT_RESET;
            config_r          <= `CFG_RESET;
            wdDisableActive_r <= CFG_INIT[`CFG_WATCHDOG_DISABLE];
            suppress_r        <= 1'b0;
            onceCnt_r         <= 7'h00;
            onceUsed_r        <= 1'b0;
        end else if (inReset) begin
            special_r         <= specialModeIn;
            options_r         <= `OPT_RESET; // RULE10 RULE17
            // The enable only moves here, so a new setting waits for reset.
            wdDisableActive_r <= config_r[`CFG_WATCHDOG_DISABLE]; // RULE6 RULE7
            suppress_r        <= specialModeIn; // RULE8
            onceCnt_r         <= 7'h00;
            onceUsed_r        <= 1'b0;
        end else begin
            if (onceCnt_r < `ONCE_WINDOW_CYCLES)
                onceCnt_r <= onceCnt_r + 7'd1;
            if (wrOpt) begin
                options_r <= (wByte_r & `OPT_ANY_MASK) |
                             ((onceOpen ? wByte_r : options_r)
                              & `OPT_ONCE_MASK); // RULE11 RULE17
                if (!special_r)
                    onceUsed_r <= 1'b1;
            end
            if (doWrite && wLane_r && awIdx_r == `IDX_SYSTEM_CONFIG)
                config_r <= wByte_r;
            if (doWrite && wLane_r && awIdx_r == `IDX_TEST_CONTROL)
                suppress_r <= wByte_r[`TEST_SUPPRESS_BIT]; // RULE8
        end
    end

    // Watchdog timer and service sequence.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wdCount_r <= {WD_W{1'b0}};
            armed_r   <= 1'b0;
        end else if (inReset) begin
            wdCount_r <= {WD_W{1'b0}};
            armed_r   <= 1'b0;
        end else begin
            if (wdClear || wdExpire)
                wdCount_r <= {WD_W{1'b0}}; // RULE13
            else
                wdCount_r <= wdCount_r + {{(WD_W-1){1'b0}}, 1'b1}; // RULE9
            if (wrSvc) begin
                if (wByte_r == `SERVICE_ARM)
                    armed_r <= 1'b1; // RULE12
                else if (wByte_r == `SERVICE_CLEAR)
                    armed_r <= 1'b0; // RULE24
            end
        end
    end

    // Registered copies of option bits for the rest of the chip.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqEdgeSelect_r     <= 1'b0;
            oscStartupDelayEn_r <= 1'b1;
            converterPowerUp_r  <= 1'b0;
            converterClockSel_r <= 1'b0;
        end else begin
            irqEdgeSelect_r     <= options_r[`OPT_IRQ_EDGE]; // RULE20
            oscStartupDelayEn_r <= options_r[`OPT_STARTUP_DLY];
            converterPowerUp_r  <= options_r[`OPT_CONVERTER_PU];
            converterClockSel_r <= options_r[`OPT_CONVERTER_CLK];
        end
    end

    // AXI4-Lite write channel: address and data in either order.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awIdx_r       <= 14'h0000;
            wByte_r       <= 8'h00;
            wLane_r       <= 1'b0;
        end else begin
            s_axi_awready <= ~awHeld_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~wHeld_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awIdx_r  <= s_axi_awaddr[15:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wByte_r <= s_axi_wdata[7:0];
                wLane_r <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(awIdx_r) ? `RESP_OKAY : `RESP_SLVERR;
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= isMapped(arIdx) ? `RESP_OKAY : `RESP_SLVERR;
                case (arIdx)
                    `IDX_SYSTEM_OPTIONS: s_axi_rdata <= {24'h000000, options_r};
                    `IDX_SYSTEM_CONFIG:  s_axi_rdata <= {24'h000000, config_r};
                    `IDX_TEST_CONTROL:
                        s_axi_rdata <= {31'h00000000, suppress_r};
                    `IDX_STATUS:
                        s_axi_rdata <= {26'h0000000, ~wdDisableActive_r,
                                        armed_r, special_r, lastWd_r,
                                        lastClock_r, lastPin_r};
                    default:             s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // reset_watchdog_clock_monitor

// ==== sim/rst_wd_sva.sv ====
`timescale 1ns/1ps
`include "reset_watchdog_clock_monitor_map.vh"
module rst_wd_sva (
    // Clock and reset.
    input wire        core_clk,
    input wire        resetn,
    // Reset pin and core reset.
    input wire        resetPinIn,
    input wire        resetPinOut,
    input wire        resetPinOe,
    input wire        specialModeIn,
    input wire        coreResetn_r,
    input wire [15:0] resetVector_r
);
    localparam int PorN = 4064;
    logic [12:0] porCnt_r;

    // Saturating count of cycles since power-on release.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            porCnt_r <= 13'h0;
        else if (porCnt_r != 13'h1FFF)
            porCnt_r <= porCnt_r + 13'h1;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_pin_four: assert property (
        $rose(resetPinOe) |-> resetPinOe[*4] ##1 !resetPinOe)
        else $error("reset pin not driven for four cycles");
    a_pin_low: assert property (resetPinOe |-> !resetPinOut)
        else $error("reset pin driven high");
    a_core_held: assert property (resetPinOe |-> !coreResetn_r)
        else $error("core released while pin driven");
    a_no_early: assert property (
        $fell(resetPinOe) |-> !coreResetn_r ##1 !coreResetn_r)
        else $error("core released before pin sample");
    a_internal_go: assert property (
        $fell(resetPinOe) ##0 resetPinIn[*2] |-> ##[1:2] coreResetn_r)
        else $error("internal reset not released");
    a_pin_ext: assert property (!resetPinIn |=> !coreResetn_r)
        else $error("core runs while pin low");
    a_por_hold: assert property (porCnt_r < PorN |-> !coreResetn_r)
        else $error("power-on hold too short");
    a_vec_norm: assert property (
        $rose(coreResetn_r) && !specialModeIn |-> resetVector_r inside
        {`VEC_NORM_PIN, `VEC_NORM_CLOCK, `VEC_NORM_WATCHDOG})
        else $error("bad normal vector");
    a_vec_spec: assert property (
        $rose(coreResetn_r) && specialModeIn |-> resetVector_r inside
        {`VEC_SPEC_PIN, `VEC_SPEC_CLOCK, `VEC_SPEC_WATCHDOG})
        else $error("bad special vector");

    c_drive: cover property ($rose(resetPinOe));
    c_internal: cover property ($fell(resetPinOe) ##0 resetPinIn[*2]);
    c_external: cover property (!resetPinIn && !resetPinOe);
    c_special: cover property ($rose(coreResetn_r) && specialModeIn);
endmodule // rst_wd_sva

bind reset_watchdog_clock_monitor rst_wd_sva i_sva (
    .core_clk(core_clk), .resetn(resetn), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .specialModeIn(specialModeIn), .coreResetn_r(coreResetn_r),
    .resetVector_r(resetVector_r));

// ==== sim/ext_reset_source.sv ====
`timescale 1ns/1ps
module ext_reset_source (
    // Clock and press request.
    input  wire       core_clk,
    input  wire       press,
    input  wire [7:0] pressLen,
    // Reset pin.
    input  wire       resetPinOe,
    output wire       resetPinIn
);
    logic [7:0] left_r = 8'h0;

    always @(posedge core_clk) begin
        if (press)
            left_r <= pressLen;
        else if (left_r != 8'h0)
            left_r <= left_r - 8'h1;
    end

    // Wired pin with a strong pull-up and no RC delay, so a release is
    // seen high at once and the cause is not misread.
    assign resetPinIn = !(resetPinOe || left_r != 8'h0);
endmodule // ext_reset_source

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "reset_watchdog_clock_monitor_map.vh"
module tb;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic [15:0] awaddr   = 16'h0;
    logic [15:0] araddr   = 16'h0;
    logic [31:0] wdata    = 32'h0;
    logic        awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid  = 1'b0, rready = 1'b0;
    logic        spec     = 1'b0, stopM = 1'b0, lost = 1'b0;
    logic        press    = 1'b0, oePrev = 1'b0;
    logic [7:0]  pressLen = 8'h0;
    logic [31:0] seed     = 32'h402625C0;
    logic [7:0]  rv;
    logic [1:0]  rsp;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] vect;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         pinIn, pinOut, pinOe, coreRst, irq_edge_select;
    int          errors = 0, n_tests = 0, cyc = 0, oeCnt = 0, k, t0;

    initial forever #20 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        oePrev <= pinOe;
        if (pinOe && !oePrev)
            oeCnt <= oeCnt + 1;
    end

    reset_watchdog_clock_monitor #(.WD_BASE_LOG2(4)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .resetPinIn(pinIn), .resetPinOut(pinOut),
        .resetPinOe(pinOe), .specialModeIn(spec), .stopModeIn(stopM),
        .rcClockLostIn(lost), .coreResetn_r(coreRst),
        .resetVector_r(vect), .irqEdgeSelect_r(irq_edge_select),
        .oscStartupDelayEn_r(), .converterPowerUp_r(),
        .converterClockSel_r());

    ext_reset_source i_ext (.core_clk(core_clk), .press(press),
        .pressLen(pressLen), .resetPinOe(pinOe), .resetPinIn(pinIn));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Service noise must never be one of the two service patterns.
    function automatic logic [7:0] noise();
        logic [31:0] r;
        r = xs();
        if (r[7:0] == `SERVICE_ARM || r[7:0] == `SERVICE_CLEAR)
            return 8'h12;
        return r[7:0];
    endfunction

    function automatic logic [15:0] vec(input logic s, input int c);
        if (c == 0)
            return s ? `VEC_SPEC_PIN : `VEC_NORM_PIN;
        if (c == 1)
            return s ? `VEC_SPEC_CLOCK : `VEC_NORM_CLOCK;
        return s ? `VEC_SPEC_WATCHDOG : `VEC_NORM_WATCHDOG;
    endfunction

    task automatic close_out();
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        chk(n < 60, 1'b1);
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [13:0] idx, output logic [7:0] d);
        int n;
        n = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1);
        d = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
        chk(n < 60, 1'b1);
        @(posedge core_clk);
    endtask

    task automatic waitOe(input int lim);
        int n;
        n = 0;
        while (pinOe !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk(pinOe, 1'b1);
    endtask

    task automatic waitCore(input int lim, input logic [15:0] v);
        int n;
        n = 0;
        while (coreRst !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk(coreRst, 1'b1);
        chk(vect, v);
    endtask

    task automatic doReset(input logic s);
        resetn <= 1'b0;
        spec <= s;
        idle(12);
        resetn <= 1'b1;
        waitCore(4200, vec(s, 0));
    endtask

    task automatic pinPress(input logic [7:0] len, input logic cl);
        pressLen <= len;
        press <= 1'b1;
        lost <= cl;
        @(posedge core_clk);
        press <= 1'b0;
        lost <= 1'b0;
        idle(8);
        chk(coreRst, 1'b0);
    endtask

    initial begin
        doReset(1'b0);
        wr(`IDX_SYSTEM_OPTIONS, 8'h09);
        wr(`IDX_SYSTEM_OPTIONS, 8'h0B);
        rd(`IDX_SYSTEM_OPTIONS, rv);
        chk(rv, 8'h09);
        wr(`IDX_SYSTEM_CONFIG, 8'h04);
        rd(`IDX_STATUS, rv);
        chk(rv[5], 1'b1);
        rd(14'h1000, rv);
        chk(rsp, `RESP_SLVERR);
        repeat (4) begin
            wr(`IDX_SERVICE, `SERVICE_ARM);
            wr(`IDX_SERVICE, noise());
            wr(`IDX_SERVICE, `SERVICE_CLEAR);
            t0 = cyc;
            idle(xs() % 12);
        end
        chk(oeCnt, 0);
        idle(10);
        wr(`IDX_SERVICE, `SERVICE_CLEAR);
        wr(`IDX_SERVICE, `SERVICE_ARM);
        wr(`IDX_SERVICE, noise());
        waitOe(100);
        chk((cyc - t0) >= 58 && (cyc - t0) <= 70, 1'b1);
        waitCore(30, vec(0, 2));
        rd(`IDX_STATUS, rv);
        chk(rv[5:0], 6'h04);
        rd(`IDX_SYSTEM_OPTIONS, rv);
        chk(rv, `OPT_RESET);
        k = oeCnt;
        idle(150);
        lost <= 1'b1;
        idle(3);
        lost <= 1'b0;
        idle(10);
        chk(oeCnt, k);
        wr(`IDX_SYSTEM_OPTIONS, 8'h08);
        lost <= 1'b1;
        waitOe(20);
        lost <= 1'b0;
        waitCore(30, vec(0, 1));
        wr(`IDX_SYSTEM_OPTIONS, 8'h08);
        stopM <= 1'b1;
        waitOe(20);
        stopM <= 1'b0;
        waitCore(30, vec(0, 1));
        pinPress(8'd20 + xs() % 20, 1'b0);
        waitCore(100, vec(0, 0));
        wr(`IDX_SYSTEM_OPTIONS, 8'h08);
        pinPress(8'd14, 1'b1);
        waitCore(100, vec(0, 0));
        doReset(1'b1);
        k = oeCnt;
        idle(100);
        chk(oeCnt, k);
        wr(`IDX_SYSTEM_OPTIONS, 8'h21);
        rd(`IDX_SYSTEM_OPTIONS, rv);
        chk(rv, 8'h21);
        chk(irq_edge_select, 1'b1);
        wr(`IDX_TEST_CONTROL, 8'h00);
        waitOe(100);
        waitCore(30, vec(1, 2));
        chk(irq_edge_select, 1'b0);
        wr(`IDX_SYSTEM_OPTIONS, 8'h08);
        lost <= 1'b1;
        waitOe(20);
        lost <= 1'b0;
        waitCore(30, vec(1, 1));
        pinPress(8'd20, 1'b0);
        waitCore(100, vec(1, 0));
        close_out();
    end

    initial begin
        idle(30000);
        errors++;
        close_out();
    end
endmodule // tb
